// [hw/als_pkg.sv]
// als_pkg: register indices, field positions, reset values and carrier types
// for the alarm and level-steering block.
// assumes: byte address of a register is its index times four.

package als_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address = index << ADDR_LSB)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_SELECT = 8'h1e;
    localparam logic [7:0] IDX_LOW_TRIG = 8'h1f;
    localparam logic [7:0] IDX_LOW_OUT = 8'h20;
    localparam logic [7:0] IDX_HIGH_TRIG = 8'h21;
    localparam logic [7:0] IDX_HIGH_OUT = 8'h22;
    localparam logic [7:0] IDX_MODE = 8'h23;
    localparam logic [7:0] IDX_STATUS = 8'h24;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h25;
    localparam logic [7:0] IDX_IRQ_EN = 8'h26;
    localparam logic [7:0] IDX_IRQ_CLR = 8'h27;
    localparam int ADDR_LSB = 2;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int ALM_SEL_LSB = 5;
    localparam int STR_SEL_LSB = 3;
    localparam int MODE_ALARM_BIT = 0;
    localparam int MODE_STEER_BIT = 1;
    localparam int MODE_VOUT_BIT = 2;
    localparam int MODE_IOUT_BIT = 3;
    localparam int EV_LOW = 0;
    localparam int EV_HIGH = 1;
    localparam int EV_STEER = 2;
    localparam int NUM_EV = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_TEMP = 3'b000,
        SRC_IAMP = 3'b001,
        SRC_GAIN = 3'b010,
        SRC_VOUT = 3'b011,
        SRC_LINE_LOW = 3'b100,
        SRC_LINE_HIGH = 3'b101
    } als_src_t;

    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_ALARM = 2'b01,
        MODE_STEER = 2'b10
    } als_mode_t;

    typedef struct packed {
        logic [7:0] temp;
        logic [7:0] iamp;
        logic [7:0] gain;
        logic [7:0] vout;
    } als_sig_t;

    typedef struct packed {
        logic [7:0] sel;
        logic [7:0] low_trig;
        logic [7:0] low_out;
        logic [7:0] high_trig;
        logic [7:0] high_out;
        logic [3:0] mode_ctl;
        logic [NUM_EV-1:0] irq_stat;
        logic [NUM_EV-1:0] irq_en;
        als_mode_t mode;
        logic alarm_low;
        logic alarm_high;
        logic [1:0] code;
        logic [7:0] dig;
        logic irq;
        logic awrdy;
        logic wrdy;
        logic have_aw;
        logic have_w;
        logic [7:0] aw_idx;
        logic [7:0] wd;
        logic wst;
        logic bvld;
        logic [1:0] bresp;
        logic arrdy;
        logic rvld;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } als_state_t;

    localparam als_state_t ST_RESET = '{
        mode: MODE_OFF, awrdy: 1'b1, wrdy: 1'b1, arrdy: 1'b1, default: '0};

endpackage : als_pkg

// [hw/als_top.sv]
// als_top: alarm comparator and level-steering encoder with an AXI4-Lite
// register file and a masked level interrupt.
// assumes: signal inputs and update strobe come from logic on clk_in.
//
// Functional notes
// R1: low alarm when selected signal is below the low trigger.
// R2: high alarm when selected signal is above the high trigger.
// R3: during low alarm, output value is the programmed low output level.
// R4: during high alarm, output value is the programmed high output level.
// R5: steering code steps 00-01, 01-10, 10-11 at levels one, two, three.
// R6: three-bit selector picks alarm input among six sources.
// R7: two-bit selector picks steering input among four analog sources.
// R8: both selectors share one control byte, read per active mode.
// R9: alarm stays off while current and voltage output enables both set.
// R10: with alarm and steering both enabled, steering mode wins.
// R11: alarm selector sits in the three top bits of the control byte.
// R12: re-evaluate on each update; release override back inside the band.

`timescale 1ns/1ps
`default_nettype none

module als_top
    import als_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // monitored signals
    input wire als_sig_t sig_in,
    input wire logic [7:0] cond_value_in,
    input wire logic upd_in,
    // conditioned outputs
    output logic [7:0] digital_output_value_out,
    output logic steer_line_low_out,
    output logic steer_line_high_out,
    output logic alarm_low_out,
    output logic alarm_high_out,
    output logic irq_out,
    // axi4-lite write
    input wire logic [ADDR_W-1:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in
);

    if (ADDR_W < ADDR_LSB + 8) begin : g_chk
        $error("ADDR_W too small for register indices");
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // codes 6 and 7 are unmapped and compare as zero
    function automatic logic [7:0] pick(input logic [2:0] src, input als_sig_t v,
                                        input logic [1:0] code);
        case (src)
            SRC_TEMP: pick = v.temp;
            SRC_IAMP: pick = v.iamp;
            SRC_GAIN: pick = v.gain;
            SRC_VOUT: pick = v.vout;
            SRC_LINE_LOW: pick = {8{code[0]}};
            SRC_LINE_HIGH: pick = {8{code[1]}};
            default: pick = 8'h00;
        endcase
    endfunction : pick

    function automatic logic mapped(input logic [7:0] idx);
        mapped = (idx >= IDX_SELECT) && (idx <= IDX_IRQ_CLR);
    endfunction : mapped

    als_state_t s_r;
    als_state_t s_nxt;
    logic [7:0] alm_val;
    logic [7:0] str_val;
    logic [7:0] ar_idx;

    assign alm_val = pick(s_r.sel[7:ALM_SEL_LSB], sig_in, s_r.code); // see R6 see R11
    assign str_val = pick({1'b0, s_r.sel[STR_SEL_LSB+1:STR_SEL_LSB]}, sig_in,
                          s_r.code); // see R7 see R8
    assign ar_idx = araddr_in[ADDR_LSB+7:ADDR_LSB];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [NUM_EV-1:0] ev;
        logic [NUM_EV-1:0] clr;
        logic [7:0] rv;
        s_nxt = s_r;
        ev = '0;
        clr = '0;
        rv = 8'h00;

        // steering dominates; both output enables disable the alarm
        if (s_r.mode_ctl[MODE_STEER_BIT]) begin
            s_nxt.mode = MODE_STEER; // see R10
        end else if (s_r.mode_ctl[MODE_ALARM_BIT] &&
                     !(s_r.mode_ctl[MODE_VOUT_BIT] && s_r.mode_ctl[MODE_IOUT_BIT])) begin
            s_nxt.mode = MODE_ALARM; // see R9
        end else begin
            s_nxt.mode = MODE_OFF;
        end

        if (upd_in) begin // see R12
            s_nxt.alarm_low = 1'b0;
            s_nxt.alarm_high = 1'b0;
            s_nxt.dig = cond_value_in;
            unique case (s_r.mode)
                MODE_ALARM: begin
                    // low wins if the thresholds overlap
                    if (alm_val < s_r.low_trig) begin
                        s_nxt.alarm_low = 1'b1; // see R1
                        s_nxt.dig = s_r.low_out; // see R3
                    end else if (alm_val > s_r.high_trig) begin
                        s_nxt.alarm_high = 1'b1; // see R2
                        s_nxt.dig = s_r.high_out; // see R4
                    end
                end
                MODE_STEER: begin
                    if (str_val >= s_r.high_trig) begin
                        s_nxt.code = 2'b11; // see R5
                    end else if (str_val >= s_r.low_out) begin
                        s_nxt.code = 2'b10;
                    end else if (str_val >= s_r.low_trig) begin
                        s_nxt.code = 2'b01;
                    end else begin
                        s_nxt.code = 2'b00;
                    end
                end
                MODE_OFF: begin
                end
            endcase
        end
        ev[EV_LOW] = s_nxt.alarm_low && !s_r.alarm_low;
        ev[EV_HIGH] = s_nxt.alarm_high && !s_r.alarm_high;
        ev[EV_STEER] = s_nxt.code != s_r.code;

        // write channel: address and data in either order
        if (s_r.awrdy && awvalid_in) begin
            s_nxt.awrdy = 1'b0;
            s_nxt.have_aw = 1'b1;
            s_nxt.aw_idx = awaddr_in[ADDR_LSB+7:ADDR_LSB];
        end
        if (s_r.wrdy && wvalid_in) begin
            s_nxt.wrdy = 1'b0;
            s_nxt.have_w = 1'b1;
            s_nxt.wd = wdata_in[7:0];
            s_nxt.wst = wstrb_in[0];
        end
        if (s_r.have_aw && s_r.have_w) begin
            s_nxt.have_aw = 1'b0;
            s_nxt.have_w = 1'b0;
            s_nxt.bvld = 1'b1;
            s_nxt.bresp = mapped(s_r.aw_idx) ? RESP_OKAY : RESP_SLVERR;
            if (s_r.wst) begin
                unique case (s_r.aw_idx)
                    IDX_SELECT: s_nxt.sel = s_r.wd;
                    IDX_LOW_TRIG: s_nxt.low_trig = s_r.wd;
                    IDX_LOW_OUT: s_nxt.low_out = s_r.wd;
                    IDX_HIGH_TRIG: s_nxt.high_trig = s_r.wd;
                    IDX_HIGH_OUT: s_nxt.high_out = s_r.wd;
                    IDX_MODE: s_nxt.mode_ctl = s_r.wd[3:0];
                    IDX_IRQ_EN: s_nxt.irq_en = s_r.wd[NUM_EV-1:0];
                    IDX_IRQ_CLR: clr = s_r.wd[NUM_EV-1:0];
                    default: begin
                    end
                endcase
            end
        end
        if (s_r.bvld && bready_in) begin
            s_nxt.bvld = 1'b0;
            s_nxt.awrdy = 1'b1;
            s_nxt.wrdy = 1'b1;
        end

        // an event in the clearing cycle survives
        s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_en);

        // read channel
        if (s_r.arrdy && arvalid_in) begin
            unique case (ar_idx)
                IDX_SELECT: rv = s_r.sel;
                IDX_LOW_TRIG: rv = s_r.low_trig;
                IDX_LOW_OUT: rv = s_r.low_out;
                IDX_HIGH_TRIG: rv = s_r.high_trig;
                IDX_HIGH_OUT: rv = s_r.high_out;
                IDX_MODE: rv = {4'h0, s_r.mode_ctl};
                IDX_STATUS: rv = {2'h0, s_r.mode, s_r.code, s_r.alarm_high, s_r.alarm_low};
                IDX_IRQ_STAT: rv = {5'h00, s_r.irq_stat};
                IDX_IRQ_EN: rv = {5'h00, s_r.irq_en};
                default: rv = 8'h00;
            endcase
            s_nxt.arrdy = 1'b0;
            s_nxt.rvld = 1'b1;
            s_nxt.rdata = {24'h000000, rv};
            s_nxt.rresp = mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_r.rvld && rready_in) begin
            s_nxt.rvld = 1'b0;
            s_nxt.arrdy = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_r <= ST_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign digital_output_value_out = s_r.dig;
    assign steer_line_low_out = s_r.code[0];
    assign steer_line_high_out = s_r.code[1];
    assign alarm_low_out = s_r.alarm_low;
    assign alarm_high_out = s_r.alarm_high;
    assign irq_out = s_r.irq;
    assign awready_out = s_r.awrdy;
    assign wready_out = s_r.wrdy;
    assign bvalid_out = s_r.bvld;
    assign bresp_out = s_r.bresp;
    assign arready_out = s_r.arrdy;
    assign rvalid_out = s_r.rvld;
    assign rresp_out = s_r.rresp;
    assign rdata_out = s_r.rdata;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence seq_alarm_upd;
        upd_in && s_r.mode == MODE_ALARM;
    endsequence
    sequence seq_steer_upd;
        upd_in && s_r.mode == MODE_STEER;
    endsequence

    a_low_alarm_set: assert property (seq_alarm_upd ##0 alm_val < s_r.low_trig
        |=> alarm_low_out && !alarm_high_out) // see R1
        else $error("low alarm not raised");
    a_high_alarm_set: assert property (seq_alarm_upd ##0
        (alm_val >= s_r.low_trig && alm_val > s_r.high_trig) |=> alarm_high_out) // see R2
        else $error("high alarm not raised");
    a_low_out_level: assert property (seq_alarm_upd ##0 alm_val < s_r.low_trig
        |=> digital_output_value_out == $past(s_r.low_out)) // see R3
        else $error("low alarm level not driven");
    // tied to the update: high_out may be rewritten while an alarm stands
    a_high_out_level: assert property (seq_alarm_upd ##0
        (alm_val >= s_r.low_trig && alm_val > s_r.high_trig)
        |=> digital_output_value_out == $past(s_r.high_out)) // see R4
        else $error("high alarm level not driven");
    a_steer_code_map: assert property (seq_steer_upd ##0 str_val >= s_r.low_trig
        && str_val < s_r.low_out && str_val < s_r.high_trig
        |=> {steer_line_high_out, steer_line_low_out} == 2'b01) // see R5
        else $error("steering code wrong at level one");
    a_alarm_temp_sel: assert property (seq_alarm_upd ##0 s_r.sel[7:5] == SRC_TEMP
        |-> alm_val == sig_in.temp) // see R6 see R11
        else $error("alarm source not temperature");
    a_steer_gain_sel: assert property (s_r.sel[4:3] == 2'b10 |-> str_val == sig_in.gain) // see R7
        else $error("steering source not gain stage");
    a_dual_out_off: assert property ((s_r.mode_ctl[MODE_VOUT_BIT] && s_r.mode_ctl[MODE_IOUT_BIT])
        [*2] ##0 upd_in |=> !alarm_low_out && !alarm_high_out) // see R9
        else $error("alarm active with both outputs");
    a_steer_dominant: assert property (s_r.mode_ctl[MODE_STEER_BIT]
        |=> s_r.mode == MODE_STEER) // see R10 see R8
        else $error("steering not dominant");
    a_band_release: assert property (seq_alarm_upd ##0 alm_val >= s_r.low_trig
        && alm_val <= s_r.high_trig |=> !alarm_low_out && !alarm_high_out
        && digital_output_value_out == $past(cond_value_in)) // see R12
        else $error("override not released in band");
    a_irq_set_wins: assert property (!alarm_low_out ##1 alarm_low_out
        |-> s_r.irq_stat[EV_LOW])
        else $error("alarm event lost");
    a_write_answer: assert property (s_r.have_aw && s_r.have_w |=> bvalid_out)
        else $error("write response missing");

endmodule : als_top

`default_nettype wire

// [tb/tb_als_top.sv]
// tb_als_top: self-checking bench for the alarm and level-steering block.
// assumes: als_pkg is compiled first; registers sit at byte address index*4.
`timescale 1ns/1ps
`default_nettype none

module tb_als_top
    import als_pkg::*;
;
    // ----------------------------------------------------------------
    // design connections
    // ----------------------------------------------------------------
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    als_sig_t sig_in = '0;
    logic [7:0] cond_value_in = 8'h00;
    logic upd_in = 1'b0;
    logic [7:0] dig_out;
    logic line_lo, line_hi, alarm_low_out, alarm_high_out, irq_out;
    logic [11:0] awaddr_in = 12'h000;
    logic [11:0] araddr_in = 12'h000;
    logic awvalid_in = 1'b0;
    logic wvalid_in = 1'b0;
    logic bready_in = 1'b0;
    logic arvalid_in = 1'b0;
    logic rready_in = 1'b0;
    logic [31:0] wdata_in = 32'h0;
    logic [3:0] wstrb_in = 4'h0;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
    logic [1:0] bresp_out, rresp_out;
    logic [31:0] rdata_out;
    // bench state: expected registers, mode bits and steering code
    logic [7:0] cfg [5];
    logic [3:0] mc = 4'h0;
    logic [1:0] ecode = 2'h0;
    logic [31:0] seed = 32'h5e81;
    logic [31:0] d;
    int n_mismatch = 0;
    int cmp_count = 0;

    als_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .sig_in(sig_in),
        .cond_value_in(cond_value_in), .upd_in(upd_in),
        .digital_output_value_out(dig_out), .steer_line_low_out(line_lo),
        .steer_line_high_out(line_hi), .alarm_low_out(alarm_low_out),
        .alarm_high_out(alarm_high_out), .irq_out(irq_out), .awaddr_in(awaddr_in),
        .awvalid_in(awvalid_in), .awready_out(awready_out), .wdata_in(wdata_in),
        .wstrb_in(wstrb_in), .wvalid_in(wvalid_in), .wready_out(wready_out),
        .bresp_out(bresp_out), .bvalid_out(bvalid_out), .bready_in(bready_in),
        .araddr_in(araddr_in), .arvalid_in(arvalid_in), .arready_out(arready_out),
        .rdata_out(rdata_out), .rresp_out(rresp_out), .rvalid_out(rvalid_out),
        .rready_in(rready_in));

    initial begin
        forever #25 clk_in = ~clk_in;
    end

    // ----------------------------------------------------------------
    // compares, expectations, verdict
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_bus

    task automatic chk_pin(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_pin

    function automatic logic [7:0] rnd();
        for (int b = 0; b < 8; b++) begin
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        end
        return seed[7:0];
    endfunction : rnd

    function automatic logic [1:0] exp_resp(input logic [7:0] idx);
        return (idx >= IDX_SELECT && idx <= IDX_IRQ_CLR) ? RESP_OKAY : RESP_SLVERR;
    endfunction : exp_resp

    // steering lines feed the alarm as all-zero or all-one bytes
    function automatic logic [7:0] pick(input logic [2:0] s, input als_sig_t g,
                                        input logic [1:0] c);
        case (s)
            3'h0: return g.temp;
            3'h1: return g.iamp;
            3'h2: return g.gain;
            3'h3: return g.vout;
            3'h4: return {8{c[0]}};
            3'h5: return {8{c[1]}};
            default: return 8'h00;
        endcase
    endfunction : pick

    // ----------------------------------------------------------------
    // axi4-lite master
    // ----------------------------------------------------------------
    task automatic axw(input logic [7:0] idx, input logic [31:0] v, input logic [3:0] st);
        awaddr_in <= {2'b00, idx, 2'b00};
        awvalid_in <= 1'b1;
        wdata_in <= v;
        wstrb_in <= st;
        wvalid_in <= 1'b1;
        bready_in <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (awvalid_in && awready_out) awvalid_in <= 1'b0;
            if (wvalid_in && wready_out) wvalid_in <= 1'b0;
            if (bvalid_out) begin
                chk_bus("bresp", {30'h0, exp_resp(idx)}, {30'h0, bresp_out});
                bready_in <= 1'b0;
                break;
            end
        end
        // one idle edge so a following request never reassigns in this step
        @(posedge clk_in);
    endtask : axw

    task automatic wr(input logic [7:0] idx, input logic [31:0] v);
        axw(idx, v, 4'hf);
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [31:0] v);
        araddr_in <= {2'b00, idx, 2'b00};
        arvalid_in <= 1'b1;
        rready_in <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (arvalid_in && arready_out) arvalid_in <= 1'b0;
            if (rvalid_out) begin
                v = rdata_out;
                chk_bus("rresp", {30'h0, exp_resp(idx)}, {30'h0, rresp_out});
                rready_in <= 1'b0;
                break;
            end
        end
        @(posedge clk_in);
    endtask : rd

    task automatic set_all();
        for (int k = 0; k < 5; k++) begin
            wr(IDX_SELECT + 8'(k), {24'h0, cfg[k]});
        end
        wr(IDX_MODE, {28'h0, mc});
    endtask : set_all

    // ----------------------------------------------------------------
    // one sample through the comparators, checked against the model
    // ----------------------------------------------------------------
    task automatic step(input als_sig_t g, input logic [7:0] c);
        logic [7:0] v;
        logic lo;
        logic hi;
        logic [7:0] ed;
        sig_in <= g;
        cond_value_in <= c;
        upd_in <= 1'b1;
        @(posedge clk_in);
        upd_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        lo = 1'b0;
        hi = 1'b0;
        ed = c;
        if (mc[MODE_STEER_BIT]) begin
            v = pick({1'b0, cfg[0][4:3]}, g, ecode);
            ecode = v >= cfg[3] ? 2'h3 : v >= cfg[2] ? 2'h2 : v >= cfg[1] ? 2'h1 : 2'h0;
        end else if (mc[MODE_ALARM_BIT] && !(mc[MODE_VOUT_BIT] && mc[MODE_IOUT_BIT])) begin
            v = pick(cfg[0][7:5], g, ecode);
            lo = v < cfg[1];
            hi = !lo && v > cfg[3];
            ed = lo ? cfg[2] : hi ? cfg[4] : c;
        end
        chk_pin("alarm_low", 8'(lo), 8'(alarm_low_out));
        chk_pin("alarm_high", 8'(hi), 8'(alarm_high_out));
        chk_pin("dig_out", ed, dig_out);
        chk_pin("steer_code", 8'(ecode), {6'h0, line_hi, line_lo});
        rd(IDX_STATUS, d);
        chk_bus("status", {28'h0, ecode, hi, lo}, d & 32'h0000000f);
    endtask : step

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (30000) @(posedge clk_in);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        static logic [3:0] modes [6] = '{4'h1, 4'h2, 4'h3, 4'hd, 4'h0, 4'h5};
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        for (int k = 8'h1e; k <= 8'h27; k++) begin
            rd(8'(k), d);
            chk_bus("reset_value", 32'h0, d);
        end
        rd(8'h10, d);
        chk_bus("unmapped_read", 32'h0, d);
        wr(8'h28, 32'h000000ff);
        axw(IDX_SELECT, 32'h000000ff, 4'h0);
        rd(IDX_SELECT, d);
        chk_bus("no_strobe", 32'h0, d);
        // boundaries on temp: equal to a trigger must not alarm
        cfg = '{8'h00, 8'h40, 8'h5a, 8'hc0, 8'ha5};
        mc = 4'h1;
        set_all();
        foreach (modes[j]) begin
            step({8'h40 - 8'(j), 24'h0}, 8'h33);
            step({8'hbf + 8'(j), 24'h0}, 8'h33);
        end
        step({8'h80, 24'h0}, 8'h11);
        wr(IDX_IRQ_CLR, 32'h7);
        wr(IDX_IRQ_EN, 32'h3);
        step({8'h10, 24'h0}, 8'h11);
        chk_pin("irq", 8'h01, 8'(irq_out));
        rd(IDX_IRQ_STAT, d);
        chk_bus("irq_stat", 32'h1, d);
        wr(IDX_IRQ_EN, 32'h0);
        repeat (2) @(posedge clk_in);
        chk_pin("irq_masked", 8'h00, 8'(irq_out));
        wr(IDX_IRQ_EN, 32'h1);
        repeat (2) @(posedge clk_in);
        chk_pin("irq", 8'h01, 8'(irq_out));
        wr(IDX_IRQ_CLR, 32'h1);
        repeat (2) @(posedge clk_in);
        chk_pin("irq_cleared", 8'h00, 8'(irq_out));
        rd(IDX_IRQ_STAT, d);
        chk_bus("irq_stat", 32'h0, d);
        wr(IDX_IRQ_EN, 32'h0);
        // random configurations over six mode-bit combinations
        for (int i = 0; i < 60; i++) begin
            mc = modes[i % 6];
            for (int k = 0; k < 5; k++) begin
                cfg[k] = rnd();
            end
            set_all();
            for (int k = 0; k < 5; k++) begin
                rd(IDX_SELECT + 8'(k), d);
                chk_bus("config", {24'h0, cfg[k]}, d);
            end
            for (int j = 0; j < 3; j++) begin
                step({rnd(), rnd(), rnd(), rnd()}, rnd());
                chk_pin("irq_masked", 8'h00, 8'(irq_out));
            end
        end
        wrap_up();
    end
endmodule : tb_als_top

`default_nettype wire
